// File: include/cbc_pkg.sv
package cbc_pkg;
	// bus clock and strobe timing, figures in ns, SYNC_LAT in cycles
	localparam int CLK_PERIOD_NS = 100;
	localparam int RD_PULSE_NS   = 235;  // least read / acknowledge strobe width
	localparam int WR_PULSE_NS   = 165;  // least write strobe width
	localparam int WR_SETUP_NS   = 240;  // least data setup to write strobe end
	localparam int RD_GAP_NS     = 160;  // least gap between read-type strobes
	localparam int WR_GAP_NS     = 190;  // least gap between write strobes
	localparam int CMD_GAP_NS    = 500;  // least gap between whole commands
	localparam int SYNC_LAT      = 2;    // extra cycles the pin synchroniser costs
	localparam int WR_NS_MAX     = (WR_PULSE_NS > WR_SETUP_NS) ? WR_PULSE_NS : WR_SETUP_NS;
	localparam int GAP_NS_MAX    = (RD_GAP_NS > WR_GAP_NS) ? RD_GAP_NS : WR_GAP_NS;

	// derived cycle counts, least times rounded up
	localparam logic [3:0] RD_CYC  =
		4'((RD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
	localparam logic [3:0] WR_CYC  = 4'((WR_NS_MAX + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] REC_CYC = 4'((GAP_NS_MAX + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] GAP_CYC = 4'((CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// system shape: one master plus up to eight slaves
	localparam int         NUM_CTRL = 9;
	localparam logic [3:0] NUM_TGT  = 4'h9;
	localparam int         DATA_W   = 8;
	localparam int         CAS_W    = 3;
	localparam int         IN_W     = DATA_W + CAS_W + 2;

	// register byte offsets on the AXI4-Lite slave
	localparam int         ADDR_W     = 5;
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_CMD    = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_RDATA  = 5'h0C;
	localparam logic [4:0] OFS_VECTOR = 5'h10;

	// control register fields
	localparam int         CTRL_BUF_BIT    = 0;
	localparam int         CTRL_MASTER_BIT = 1;
	localparam int         CTRL_CPU16_BIT  = 2;
	localparam logic [2:0] CTRL_RESET      = 3'h2;

	// command register fields
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_A0_BIT   = 8;
	localparam int CMD_TGT_LSB  = 12;
	localparam int CMD_TGT2_LSB = 16;
	localparam int CMD_OP_LSB   = 20;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_READ  = 3'h2;
	localparam logic [2:0] OP_ACK   = 3'h3;
	localparam logic [2:0] OP_EOI2  = 3'h4;
	localparam logic [2:0] OP_INIT4 = 3'h5;

	// status register fields, error bits are write-one-to-clear
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_INT_BIT  = 1;
	localparam int ST_EN_BIT   = 2;
	localparam int ST_CAS_LSB  = 4;
	localparam int ST_ERR_BUF  = 8;
	localparam int ST_ERR_CAS  = 9;
	localparam int ST_ERR_REF  = 10;

	// fourth init word bits
	localparam int FOURTH_BUF_BIT    = 3;
	localparam int FOURTH_MASTER_BIT = 2;

	// strobe kinds and AXI answers
	localparam logic [1:0] K_WR     = 2'h0;
	localparam logic [1:0] K_RD     = 2'h1;
	localparam logic [1:0] K_ACK    = 2'h2;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_GAP} cbc_state_e;

	// pins driven toward the controllers
	typedef struct packed {
		logic [NUM_CTRL-1:0] cs_n;
		logic                a0;
		logic                rd_n;
		logic                wr_n;
		logic                interrupt_acknowledge_n;
		logic [DATA_W-1:0]   data_out;
		logic                data_oe;
		logic                bus_buffer_enable_out_drv;
		logic                bus_buffer_enable_out_oe;
	} cbc_pins_s;
endpackage

// File: rtl/cbc_host.sv
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// [RULE_01] device enables buffers while driving data
// [RULE_02] bit 3 of fourth word selects buffering
// [RULE_03] buffered role comes from fourth word bit 2
// [RULE_04] one master, eight slaves, 64 levels
// [RULE_05] master drives 3-bit slave id
// [RULE_06] slave answers only on matching id
// [RULE_07] slave returns vector in later acknowledge bytes
// [RULE_08] cascade lines low idle, held across sequence
// [RULE_09] each controller initialised separately
// [RULE_10] end-of-service sent to master and slave
// [RULE_11] slave supports automatic service clear
// [RULE_12] cascade driven only for slave inputs
// [RULE_13] use slave id 0 last
// [RULE_14] separate chip select per controller
// [RULE_15] special nested master sees higher slave requests
// [RULE_16] unbuffered pin selects master high, slave low
module cbc_host (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      ce,
	input  wire logic [cbc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [cbc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output cbc_pkg::cbc_pins_s             pins,
	input  wire logic [7:0]                data_in,
	input  wire logic [2:0]                cascade_select_lines,
	input  wire logic                      int_in,
	input  wire logic                      bus_buffer_enable_out_in
);
	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [cbc_pkg::IN_W-1:0]   sync1, sync2, sync3, in_st;  // pin synchroniser
	logic [7:0]                 data_st;                     // settled data bus
	logic [2:0]                 cas_st;                      // settled cascade lines
	logic                       int_st;                      // settled interrupt
	logic                       en_st;                       // settled buffer enable, low active
	logic                       aw_full, w_full;             // write channels held
	logic [cbc_pkg::ADDR_W-1:0] awaddr_r;
	logic [31:0]                wdata_r;
	logic [3:0]                 wstrb_r;
	logic                       wr_fire, wr_hit, cmd_wr;
	logic [2:0]                 ctrl;                        // buffered, master, 16-bit format
	cbc_pkg::cbc_state_e        state;
	logic [3:0]                 cnt;                         // cycles left in state
	logic [1:0]                 phase, nphase;               // strobe index, strobes per op
	logic [2:0]                 op_r;
	logic [7:0]                 byte_r;                      // byte to drive on writes
	logic                       a0_r;
	logic [3:0]                 tgt_r, tgt2_r;               // chip select indices
	logic [1:0]                 kind;                        // strobe kind of this phase
	logic [3:0]                 cur_tgt;
	logic                       in_cycle;                    // setup, strobe or recover
	logic                       strobe_end;
	logic [7:0]                 rdata_r;                     // last read byte
	logic [23:0]                vec_r;                       // acknowledge bytes 1..3
	logic [2:0]                 cas_seen;                    // cascade id during acknowledge
	logic                       err_buf, err_cas, err_ref;
	logic [2:0]                 c_op;
	logic [3:0]                 c_tgt, c_tgt2;
	logic [7:0]                 c_byte;
	logic                       start;
	logic [31:0]                rd_word;
	logic                       rd_hit;
	logic [2:0]                 ack_falls;                   // helper for checks only

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser: a change counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			in_st <= '0;
		end else if (ce) begin
			sync1 <= {data_in, cascade_select_lines, int_in, bus_buffer_enable_out_in};
			sync2 <= sync1;
			sync3 <= sync2;
			in_st <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & in_st);
		end
	end
	assign data_st = in_st[12:5];
	assign cas_st  = in_st[4:2];
	assign int_st  = in_st[1];
	assign en_st   = in_st[0];

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write side: address and data taken in either order
	assign s_axi_awready = ce && !aw_full;
	assign s_axi_wready  = ce && !w_full;
	assign wr_fire       = ce && aw_full && w_full && !s_axi_bvalid;
	assign wr_hit        = (awaddr_r == cbc_pkg::OFS_CTRL) || (awaddr_r == cbc_pkg::OFS_CMD) ||
		(awaddr_r == cbc_pkg::OFS_STATUS);
	assign cmd_wr        = wr_fire && (awaddr_r == cbc_pkg::OFS_CMD);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full      <= 1'b0;
			w_full       <= 1'b0;
			awaddr_r     <= '0;
			wdata_r      <= '0;
			wstrb_r      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= cbc_pkg::RESP_OK;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full  <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full  <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? cbc_pkg::RESP_OK : cbc_pkg::RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control register, low byte lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= cbc_pkg::CTRL_RESET;
		end else if (ce && wr_fire && awaddr_r == cbc_pkg::OFS_CTRL && wstrb_r[0]) begin
			ctrl <= wdata_r[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command decode; fourth word gets its mode bits from control
	assign c_op   = wdata_r[cbc_pkg::CMD_OP_LSB +: 3];
	assign c_tgt  = wdata_r[cbc_pkg::CMD_TGT_LSB +: 4];
	assign c_tgt2 = wdata_r[cbc_pkg::CMD_TGT2_LSB +: 4];

	always_comb begin
		// automatic clear and nesting bits pass as software gives them
		c_byte = wdata_r[cbc_pkg::CMD_DATA_LSB +: 8]; // see [RULE_11] [RULE_15]
		if (c_op == cbc_pkg::OP_INIT4) begin
			c_byte[cbc_pkg::FOURTH_BUF_BIT]    = ctrl[cbc_pkg::CTRL_BUF_BIT];    // see [RULE_02]
			c_byte[cbc_pkg::FOURTH_MASTER_BIT] = ctrl[cbc_pkg::CTRL_MASTER_BIT]; // see [RULE_03]
		end
	end

	// bad target or unknown op is refused, as is any command while busy
	assign start = cmd_wr && (state == cbc_pkg::ST_IDLE) && (c_tgt < cbc_pkg::NUM_TGT) && // see [RULE_14]
		(c_op != cbc_pkg::OP_EOI2 || c_tgt2 < cbc_pkg::NUM_TGT) &&
		(c_op >= cbc_pkg::OP_WRITE) && (c_op <= cbc_pkg::OP_INIT4);

	// strobe kind and chip select of the current phase
	always_comb begin
		kind    = cbc_pkg::K_WR;
		cur_tgt = tgt_r;
		case (op_r)
			cbc_pkg::OP_READ: kind = cbc_pkg::K_RD;
			cbc_pkg::OP_ACK:  kind = cbc_pkg::K_ACK;
			cbc_pkg::OP_EOI2: cur_tgt = (phase == 2'h0) ? tgt_r : tgt2_r; // see [RULE_10]
			default:          kind = cbc_pkg::K_WR;
		endcase
	end

	assign in_cycle   = (state == cbc_pkg::ST_SETUP) || (state == cbc_pkg::ST_STROBE) ||
		(state == cbc_pkg::ST_RECOVER);
	assign strobe_end = ce && (state == cbc_pkg::ST_STROBE) && (cnt == 4'h0);

	////////////////////////////////////////////////////////////////////////
	// sequencer: setup, strobe, recover per phase, then command gap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state  <= cbc_pkg::ST_IDLE;
			cnt    <= 4'h0;
			phase  <= 2'h0;
			nphase <= 2'h1;
			op_r   <= cbc_pkg::OP_WRITE;
			byte_r <= 8'h00;
			a0_r   <= 1'b0;
			tgt_r  <= 4'h0;
			tgt2_r <= 4'h0;
		end else if (ce) begin
			case (state)
				cbc_pkg::ST_IDLE: begin
					if (start) begin
						state  <= cbc_pkg::ST_SETUP;
						phase  <= 2'h0;
						op_r   <= c_op;
						byte_r <= c_byte;
						a0_r   <= wdata_r[cbc_pkg::CMD_A0_BIT] || (c_op == cbc_pkg::OP_INIT4);
						tgt_r  <= c_tgt;
						tgt2_r <= c_tgt2;
						// two bytes in 16-bit format, three in 8-bit format
						if (c_op == cbc_pkg::OP_ACK) begin
							nphase <= ctrl[cbc_pkg::CTRL_CPU16_BIT] ? 2'h2 : 2'h3;
						end else if (c_op == cbc_pkg::OP_EOI2) begin
							nphase <= 2'h2; // see [RULE_10]
						end else begin
							nphase <= 2'h1;
						end
					end
				end
				cbc_pkg::ST_SETUP: begin
					state <= cbc_pkg::ST_STROBE;
					cnt   <= ((kind == cbc_pkg::K_WR) ? cbc_pkg::WR_CYC : cbc_pkg::RD_CYC) - 4'h1;
				end
				cbc_pkg::ST_STROBE: begin
					if (cnt == 4'h0) begin
						state <= cbc_pkg::ST_RECOVER;
						cnt   <= cbc_pkg::REC_CYC - 4'h1;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				cbc_pkg::ST_RECOVER: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else if (phase == nphase - 2'h1) begin
						state <= cbc_pkg::ST_GAP; // see [RULE_09]
						cnt   <= cbc_pkg::GAP_CYC - 4'h1;
					end else begin
						state <= cbc_pkg::ST_SETUP;
						phase <= phase + 2'h1;
					end
				end
				cbc_pkg::ST_GAP: begin
					if (cnt == 4'h0) begin
						state <= cbc_pkg::ST_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				default: state <= cbc_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// capture read byte and acknowledge bytes at the strobe end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_r  <= 8'h00;
			vec_r    <= 24'h000000;
			cas_seen <= 3'h0;
		end else if (strobe_end) begin
			if (kind == cbc_pkg::K_RD) begin
				rdata_r <= data_st;
			end
			if (kind == cbc_pkg::K_ACK) begin
				vec_r[phase*8 +: 8] <= data_st; // chosen slave's vector, see [RULE_06]
				cas_seen            <= cas_st;  // id put out, see [RULE_05]
			end
		end
	end

	// sticky errors: hardware set wins over software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_buf <= 1'b0;
			err_cas <= 1'b0;
			err_ref <= 1'b0;
		end else if (ce) begin
			if (wr_fire && awaddr_r == cbc_pkg::OFS_STATUS && wstrb_r[1]) begin
				err_buf <= err_buf & ~wdata_r[cbc_pkg::ST_ERR_BUF];
				err_cas <= err_cas & ~wdata_r[cbc_pkg::ST_ERR_CAS];
				err_ref <= err_ref & ~wdata_r[cbc_pkg::ST_ERR_REF];
			end
			// buffered: enable low while device drives, high when idle
			if (ctrl[cbc_pkg::CTRL_BUF_BIT] && ((strobe_end && kind != cbc_pkg::K_WR && en_st) ||
				(state == cbc_pkg::ST_IDLE && !en_st))) begin
				err_buf <= 1'b1; // see [RULE_01]
			end
			// cascade low when idle, same id on every later acknowledge byte
			if ((state == cbc_pkg::ST_IDLE && cas_st != 3'h0) || (strobe_end &&
				kind == cbc_pkg::K_ACK && phase != 2'h0 && cas_st != cas_seen)) begin
				err_cas <= 1'b1; // see [RULE_08] [RULE_12]
			end
			if (cmd_wr && !start) begin
				err_ref <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive, decoded from registered state
	always_comb begin
		pins                         = '0;
		pins.cs_n                    = '1;
		if (in_cycle && kind != cbc_pkg::K_ACK) begin
			pins.cs_n = ~(9'h001 << cur_tgt); // see [RULE_14]
		end
		pins.a0                      = a0_r && (kind != cbc_pkg::K_ACK);
		pins.rd_n                    = !(state == cbc_pkg::ST_STROBE && kind == cbc_pkg::K_RD);
		pins.wr_n                    = !(state == cbc_pkg::ST_STROBE && kind == cbc_pkg::K_WR);
		pins.interrupt_acknowledge_n = !(state == cbc_pkg::ST_STROBE && kind == cbc_pkg::K_ACK);
		pins.data_out                = byte_r;
		pins.data_oe                 = in_cycle && (kind == cbc_pkg::K_WR);
		// strap the role only while the pin is an input to the device
		pins.bus_buffer_enable_out_drv = ctrl[cbc_pkg::CTRL_MASTER_BIT]; // see [RULE_16]
		pins.bus_buffer_enable_out_oe  = !ctrl[cbc_pkg::CTRL_BUF_BIT];   // see [RULE_03]
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read side
	assign s_axi_arready = ce && !s_axi_rvalid;

	always_comb begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			cbc_pkg::OFS_CTRL:   rd_word[2:0] = ctrl;
			cbc_pkg::OFS_STATUS: begin
				rd_word[cbc_pkg::ST_BUSY_BIT]     = (state != cbc_pkg::ST_IDLE);
				rd_word[cbc_pkg::ST_INT_BIT]      = int_st;
				rd_word[cbc_pkg::ST_EN_BIT]       = en_st;
				rd_word[cbc_pkg::ST_CAS_LSB +: 3] = cas_seen;
				rd_word[cbc_pkg::ST_ERR_BUF]      = err_buf;
				rd_word[cbc_pkg::ST_ERR_CAS]      = err_cas;
				rd_word[cbc_pkg::ST_ERR_REF]      = err_ref;
			end
			cbc_pkg::OFS_CMD:    rd_word[7:0] = byte_r;
			cbc_pkg::OFS_RDATA:  rd_word[7:0] = rdata_r;
			cbc_pkg::OFS_VECTOR: rd_word[23:0] = vec_r;
			default:             rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= cbc_pkg::RESP_OK;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? cbc_pkg::RESP_OK : cbc_pkg::RESP_ERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks; helper counts acknowledge pulses of one sequence
	always_ff @(posedge aclk) begin
		if (!aresetn || (ce && state == cbc_pkg::ST_IDLE)) begin
			ack_falls <= 3'h0;
		end else if (ce && state == cbc_pkg::ST_SETUP && kind == cbc_pkg::K_ACK) begin
			ack_falls <= ack_falls + 3'h1;
		end
	end

	AST_ROLE_STRAP: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_16]
		!ctrl[cbc_pkg::CTRL_BUF_BIT] |-> pins.bus_buffer_enable_out_oe &&
		pins.bus_buffer_enable_out_drv == ctrl[cbc_pkg::CTRL_MASTER_BIT])
		else $error("role strap not driven while unbuffered");
	AST_ROLE_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_03]
		$rose(ctrl[cbc_pkg::CTRL_BUF_BIT]) |-> !pins.bus_buffer_enable_out_oe)
		else $error("role pin still driven in buffered mode");
	AST_ONE_CS: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_14]
		$onehot0(~pins.cs_n) && (pins.interrupt_acknowledge_n || pins.cs_n == '1))
		else $error("more than one chip select active");
	AST_INIT4_BITS: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_02]
		(start && c_op == cbc_pkg::OP_INIT4) |=> byte_r[3] == $past(ctrl[0]) &&
		byte_r[2] == $past(ctrl[1]) && a0_r)
		else $error("fourth word mode bits wrong");
	AST_EOI_SECOND: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_10]
		(op_r == cbc_pkg::OP_EOI2 && state == cbc_pkg::ST_STROBE) |->
		pins.cs_n == ~(9'h001 << ((phase == 2'h0) ? tgt_r : tgt2_r)))
		else $error("end-of-service sent to wrong controller");
	AST_ACK_COUNT: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_07]
		(state == cbc_pkg::ST_GAP && op_r == cbc_pkg::OP_ACK) |->
		ack_falls == {1'b0, nphase} && nphase == (ctrl[2] ? 2'h2 : 2'h3) || $changed(ctrl))
		else $error("acknowledge pulse count wrong");
	AST_WR_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_09]
		$fell(pins.wr_n) |-> (!pins.wr_n && pins.cs_n != '1 && pins.data_oe)[*3])
		else $error("write strobe too short");
	AST_GAP_QUIET: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_09]
		(state == cbc_pkg::ST_GAP) |-> pins.cs_n == '1 && pins.rd_n && pins.wr_n &&
		pins.interrupt_acknowledge_n)
		else $error("bus active during command gap");
	AST_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE_04]
		(cmd_wr && c_tgt >= cbc_pkg::NUM_TGT) |=> err_ref && $stable(op_r))
		else $error("bad chip select index not refused");
endmodule

// File: dv/cbc_dev.sv
`timescale 1ns/10ps
// behavioural cascade: master on cs 0, one slave that returns the vector
module cbc_dev #(
	parameter logic [2:0] SLV  = 3'h5, // nonzero, id 0 kept for last
	parameter logic [7:0] VEC  = 8'h48,
	parameter logic [7:0] CALL = 8'hCD
) (
	input  wire logic               aclk,
	input  wire logic               cpu16,
	input  wire cbc_pkg::cbc_pins_s pins,
	output logic [7:0]              data_in,
	output logic [2:0]              cascade_select_lines,
	output logic                    bus_buffer_enable_out_in
);
	logic [7:0] mem [9];              // last byte per controller
	logic [7:0] idle_pat = 8'h00;     // released bus never shows a stale byte
	logic [1:0] pulses   = 2'h0;      // finished acknowledge pulses
	logic       active   = 1'b0;
	logic       buffered = 1'b0;
	logic       role_bit = 1'b0;
	logic       ack_d    = 1'b1;
	logic       drive;
	logic       master;
	logic [7:0] val;
	int         cs_idx;
	////////////////////////////////////////////////////////////////////////
	// bus drivers: role pin, cascade lines, data bus
	assign master = buffered ? role_bit : bus_buffer_enable_out_in;
	assign bus_buffer_enable_out_in = pins.bus_buffer_enable_out_oe ?
		pins.bus_buffer_enable_out_drv : !(buffered && drive);
	assign cascade_select_lines = ((active || !pins.interrupt_acknowledge_n) && master) ?
		SLV : 3'h0;
	assign data_in = val;
	always_comb begin
		cs_idx = -1;
		for (int i = 0; i < 9; i++) if (!pins.cs_n[i]) cs_idx = i;
		drive = 1'b0;
		val = idle_pat;
		// first byte from the master, later ones only from the matching slave
		if (!pins.rd_n && cs_idx >= 0) begin
			drive = 1'b1;
			val = mem[cs_idx];
		end else if (!pins.interrupt_acknowledge_n && pulses == 2'h0) begin
			drive = 1'b1;
			val = CALL;
		end else if (!pins.interrupt_acknowledge_n && cascade_select_lines == SLV) begin
			drive = 1'b1;
			val = VEC + 8'(pulses) - 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// write capture and acknowledge sequence tracking
	always @(posedge aclk) begin
		if (drive) idle_pat <= ~val;
		ack_d <= pins.interrupt_acknowledge_n;
		if (!pins.wr_n && cs_idx >= 0) begin
			mem[cs_idx] <= pins.data_out;
			if (pins.a0) begin
				buffered <= pins.data_out[3];
				role_bit <= pins.data_out[2];
			end
		end
		if (!pins.interrupt_acknowledge_n) active <= 1'b1;
		// lines drop one cycle after the trailing edge of the last pulse of a sequence
		if (pins.interrupt_acknowledge_n && !ack_d) begin
			if (pulses == (cpu16 ? 2'h1 : 2'h2)) begin
				active <= 1'b0;
				pulses <= 2'h0;
			end else begin
				pulses <= pulses + 2'h1;
			end
		end
	end
endmodule

// File: dv/tb.sv
`timescale 1ns/10ps
module tb;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [4:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, s;
	logic [1:0] bresp, rresp, rsp;
	logic awready, wready, bvalid, arready, rvalid, int_in = 0, en_in, cpu16 = 0;
	logic [7:0] din, b, exp_mem [9];
	logic [2:0] cas;
	cbc_pkg::cbc_pins_s pins;
	int failures = 0, n_tests = 0, cyc = 0;
	always #50 aclk = ~aclk;
	cbc_host uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
		.data_in(din), .cascade_select_lines(cas), .int_in(int_in),
		.bus_buffer_enable_out_in(en_in));
	cbc_dev dev (.aclk(aclk), .cpu16(cpu16), .pins(pins), .data_in(din),
		.cascade_select_lines(cas), .bus_buffer_enable_out_in(en_in));
	task end_sim;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// hang guard, the whole run needs under a thousand cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			end_sim;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// axi4-lite master, one transfer at a time
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid) @(posedge aclk);
		rsp = bresp;
		bready <= 0;
	endtask
	task rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		while (!rvalid) @(posedge aclk);
		d = rdata;
		rsp = rresp;
		rready <= 0;
	endtask
	// one pin command, then poll until the controller is idle again
	task cmd(input logic [2:0] op, input logic [3:0] t, input logic [3:0] t2, input logic [7:0] d);
		wr(cbc_pkg::OFS_CMD, {9'h0, op, t2, t, 4'h0, d});
		do rd(cbc_pkg::OFS_STATUS, s); while (s[0]);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hDA0DB6AE));
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		int_in  <= 1;
		rd(cbc_pkg::OFS_CTRL, s);
		chk(s[2:0], cbc_pkg::CTRL_RESET);
		rd(5'h14, s);
		chk(rsp, cbc_pkg::RESP_ERR);
		// every controller gets its own chip select
		for (int i = 0; i < 9; i++) begin
			b = 8'($urandom);
			exp_mem[i] = b;
			cmd(cbc_pkg::OP_WRITE, 4'(i), 4'h0, b);
			chk(dev.mem[i], exp_mem[i]);
			cmd(cbc_pkg::OP_READ, 4'(i), 4'h0, 8'h00);
			rd(cbc_pkg::OFS_RDATA, s);
			chk(s[7:0], exp_mem[i]);
		end
		cmd(cbc_pkg::OP_EOI2, 4'h2, 4'h0, 8'h20);
		chk({dev.mem[2], dev.mem[0]}, 16'h2020);
		cmd(cbc_pkg::OP_WRITE, 4'h9, 4'h0, 8'h11);
		rd(cbc_pkg::OFS_STATUS, s);
		chk(s[10], 1'b1);
		chk(s[1], 1'b1);
		wr(cbc_pkg::OFS_STATUS, 32'h0000_0400);
		rd(cbc_pkg::OFS_STATUS, s);
		chk(s[10:8], 3'h0);
		// three acknowledge bytes, vector in the later two
		cmd(cbc_pkg::OP_ACK, 4'h0, 4'h0, 8'h00);
		rd(cbc_pkg::OFS_VECTOR, s);
		chk(s[23:0], 24'h4948CD);
		wr(cbc_pkg::OFS_CTRL, 32'h6);
		cpu16 <= 1;
		chk(rsp, cbc_pkg::RESP_OK);
		cmd(cbc_pkg::OP_ACK, 4'h0, 4'h0, 8'h00);
		rd(cbc_pkg::OFS_VECTOR, s);
		chk(s[15:8], 8'h48);
		// buffered master: role from the fourth word, enable follows the drivers
		wr(cbc_pkg::OFS_CTRL, 32'h3);
		cpu16 <= 0;
		cmd(cbc_pkg::OP_INIT4, 4'h0, 4'h0, 8'h00);
		chk({dev.buffered, dev.role_bit, pins.bus_buffer_enable_out_oe}, 3'h6);
		cmd(cbc_pkg::OP_ACK, 4'h0, 4'h0, 8'h00);
		rd(cbc_pkg::OFS_STATUS, s);
		chk(s[9:8], 2'h0);
		rd(cbc_pkg::OFS_VECTOR, s);
		chk(s[23:0], 24'h4948CD);
		end_sim;
	end
endmodule
